// >>> ssa_alu_regs.vh
`ifndef SSA_ALU_REGS_VH
`define SSA_ALU_REGS_VH

// Register byte offsets
`define SSA_ACC_OFS 7'h00
`define SSA_STATUS_OFS 7'h04
`define SSA_CMD_OFS 7'h08
`define SSA_MEM_BASE 7'h40

// Status register fields
`define SSA_C_BIT 0
`define SSA_NIB_BORROW_BIT 1
`define SSA_Z_BIT 2
`define SSA_SIGNED_OVR_BIT 3
`define SSA_SIGNED_BORROW_BIT 4
`define SSA_CHAIN_NULL_BIT 5
`define SSA_SKIP_BIT 8
`define SSA_BUSY_BIT 9
`define SSA_FLAGS_W 6

// Command word fields
`define SSA_CMD_OP_LSB 0
`define SSA_CMD_OP_W 3
`define SSA_CMD_ADDR_LSB 8
`define SSA_CMD_IMM_LSB 16

// Operation codes
`define SSA_OP_NOP 3'h0
`define SSA_OP_SKIP_NZ 3'h1
`define SSA_OP_SUB_MEM 3'h2
`define SSA_OP_DIFF_MEM 3'h3
`define SSA_OP_SUB_IMM 3'h4
`define SSA_OP_SWAP 3'h5

// Reset values
`define SSA_ACC_RST 8'h00
`define SSA_FLAGS_RST 6'h00

// Data memory geometry
`define SSA_MEM_DEPTH 16
`define SSA_MEM_AW 4

`endif

// >>> ssa_alu.v
`include "ssa_alu_regs.vh"
`default_nettype none

// Overview of operation
// RULE_01: Nonzero-skip rereads byte, writes back, skips.
// RULE_02: Taken skip inserts one dummy cycle.
// RULE_03: Zero byte: no skip, flags untouched.
// RULE_04: Accumulator minus memory byte into accumulator.
// RULE_05: Borrow-inverse clear if negative, else set.
// RULE_06: Subtractions update all six status flags.
// RULE_07: Difference to memory, accumulator kept.
// RULE_08: Accumulator minus immediate into accumulator.
// RULE_09: Swap memory byte nibbles, flags untouched.
// RULE_10: All datapath values are eight bits.
module ssa_alu (
   input wire clk,
   input wire rstn,
   input wire [6:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   output reg dummy_cycle
);

   localparam ST_IDLE = 2'd0;
   localparam ST_EXEC = 2'd1;
   localparam ST_DUMMY = 2'd2;

   reg [1:0] state_reg;
   reg [7:0] acc_reg; // RULE_10
   reg [`SSA_FLAGS_W-1:0] flags_reg;
   reg skip_reg;
   reg [2:0] op_reg;
   reg [`SSA_MEM_AW-1:0] addr_reg;
   reg [7:0] imm_reg;
   reg [7:0] mem [0:`SSA_MEM_DEPTH-1];

   wire busy = (state_reg != ST_IDLE);
   wire req = avs_read | avs_write;
   wire bus_write = avs_write & ~avs_waitrequest;
   wire mem_sel = (avs_address[6] == 1'b1);
   wire [`SSA_MEM_AW-1:0] bus_idx = avs_address[`SSA_MEM_AW+1:2];
   wire mem_hit = mem_sel && (avs_address[5:0] < (`SSA_MEM_DEPTH * 4))
                  && (avs_address[1:0] == 2'b00);

   // Operand selection and subtraction
   wire [7:0] mem_val = mem[addr_reg];
   wire [7:0] sub_b = (op_reg == `SSA_OP_SUB_IMM) ? imm_reg : mem_val; // RULE_08
   wire [8:0] diff9 = {1'b0, acc_reg} - {1'b0, sub_b};
   wire [4:0] diff5 = {1'b0, acc_reg[3:0]} - {1'b0, sub_b[3:0]};
   wire [7:0] diff = diff9[7:0];
   wire f_c = ~diff9[8]; // RULE_05
   wire f_nib = ~diff5[4];
   wire f_z = (diff == 8'h00);
   wire f_ovr = (acc_reg[7] ^ sub_b[7]) & (diff[7] ^ acc_reg[7]);
   // Signed no-borrow: inverted true sign of the difference, corrected for overflow
   wire f_sgn = ~(f_ovr ^ diff[7]);
   // Plain subtract has no incoming borrow, so the chained zero equals zero
   wire f_chz = f_z;
   wire [`SSA_FLAGS_W-1:0] sub_flags;
   assign sub_flags[`SSA_C_BIT] = f_c;
   assign sub_flags[`SSA_NIB_BORROW_BIT] = f_nib;
   assign sub_flags[`SSA_Z_BIT] = f_z;
   assign sub_flags[`SSA_SIGNED_OVR_BIT] = f_ovr;
   assign sub_flags[`SSA_SIGNED_BORROW_BIT] = f_sgn;
   assign sub_flags[`SSA_CHAIN_NULL_BIT] = f_chz;
   wire is_sub = (op_reg == `SSA_OP_SUB_MEM) || (op_reg == `SSA_OP_DIFF_MEM) ||
                 (op_reg == `SSA_OP_SUB_IMM);
   wire take_skip = (op_reg == `SSA_OP_SKIP_NZ) && (mem_val != 8'h00); // RULE_01

   reg [31:0] rd_next;
   always @* begin
      rd_next = 32'h0000_0000;
      if (mem_hit) begin
         rd_next = {24'h00_0000, mem[bus_idx]};
      end else begin
         case (avs_address)
            `SSA_ACC_OFS: rd_next = {24'h00_0000, acc_reg};
            `SSA_STATUS_OFS: begin
               rd_next[`SSA_FLAGS_W-1:0] = flags_reg;
               rd_next[`SSA_SKIP_BIT] = skip_reg;
               rd_next[`SSA_BUSY_BIT] = busy;
            end
            `SSA_CMD_OFS: rd_next = {8'h00, imm_reg, 4'h0, addr_reg, 5'h00, op_reg};
            default: rd_next = 32'h0000_0000;
         endcase
      end
   end

   // Bus answer: one wait cycle per access; held off while an operation runs
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else if (req && avs_waitrequest && !busy) begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= rd_next;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // Data memory: bus writes only while idle, the executing op otherwise
   always @(posedge clk) begin
      if (state_reg == ST_EXEC) begin
         case (op_reg)
            `SSA_OP_SKIP_NZ: mem[addr_reg] <= mem_val; // RULE_01
            `SSA_OP_DIFF_MEM: mem[addr_reg] <= diff; // RULE_07
            `SSA_OP_SWAP: mem[addr_reg] <= {mem_val[3:0], mem_val[7:4]}; // RULE_09
            default: mem[addr_reg] <= mem_val;
         endcase
      end else if (bus_write && mem_hit) begin
         mem[bus_idx] <= avs_writedata[7:0];
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         acc_reg <= `SSA_ACC_RST;
         flags_reg <= `SSA_FLAGS_RST;
         skip_reg <= 1'b0;
         op_reg <= `SSA_OP_NOP;
         addr_reg <= {`SSA_MEM_AW{1'b0}};
         imm_reg <= 8'h00;
         dummy_cycle <= 1'b0;
      end else begin
         dummy_cycle <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (bus_write && !mem_hit) begin
                  case (avs_address)
                     `SSA_ACC_OFS: acc_reg <= avs_writedata[7:0];
                     `SSA_STATUS_OFS: flags_reg <= avs_writedata[`SSA_FLAGS_W-1:0];
                     `SSA_CMD_OFS: begin
                        op_reg <= avs_writedata[`SSA_CMD_OP_LSB+`SSA_CMD_OP_W-1:
                                                `SSA_CMD_OP_LSB];
                        addr_reg <= avs_writedata[`SSA_CMD_ADDR_LSB+`SSA_MEM_AW-1:
                                                  `SSA_CMD_ADDR_LSB];
                        imm_reg <= avs_writedata[`SSA_CMD_IMM_LSB+7:`SSA_CMD_IMM_LSB];
                        state_reg <= ST_EXEC;
                     end
                     default: state_reg <= ST_IDLE;
                  endcase
               end
            end
            ST_EXEC: begin
               if (is_sub) begin
                  flags_reg <= sub_flags; // RULE_06
               end
               if ((op_reg == `SSA_OP_SUB_MEM) || (op_reg == `SSA_OP_SUB_IMM)) begin
                  acc_reg <= diff; // RULE_04
               end
               skip_reg <= take_skip; // RULE_03
               if (take_skip) begin
                  state_reg <= ST_DUMMY; // RULE_02
                  dummy_cycle <= 1'b1;
               end else begin
                  state_reg <= ST_IDLE; // RULE_03
               end
            end
            ST_DUMMY: state_reg <= ST_IDLE; // RULE_02
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

endmodule

`default_nettype wire

// >>> ssa_alu_asserts.sv
`default_nettype none
module ssa_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [6:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic dummy_cycle
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire logic done = !avs_waitrequest;
   wait_pulse_a: assert property (done |=> !done) else $error("wait low too long");
   dummy_pulse_a: assert property (dummy_cycle |=> !dummy_cycle) else $error("dummy long");
   dummy_cause_a: assert property (dummy_cycle |->
      $past(done && avs_write && avs_address == 7'h08, 2)) else $error("dummy uncaused");
   dummy_stall_a: assert property (dummy_cycle |-> !done) else $error("answer in dummy");
   read_answer_a: assert property ($rose(avs_read) |-> ##[1:5] done) else $error("no answer");
   rdata_width_a: assert property (done && avs_read && avs_address != 7'h04
      |-> avs_readdata[31:8] == 0) else $error("read high bits");
   status_bits_a: assert property (done && avs_read && avs_address == 7'h04
      |-> avs_readdata[31:10] == 0 && avs_readdata[7:6] == 0) else $error("status bits");
   rdata_hold_a: assert property (done && avs_read |=> $stable(avs_readdata))
      else $error("read data moved");
   cover property (dummy_cycle);
   cover property (done && avs_write && avs_address == 7'h08);
   cover property (done && avs_read && avs_address == 7'h04);
endmodule
`default_nettype wire

// >>> tb_subtract_skip_swap_alu.sv
`default_nettype none
module tb_subtract_skip_swap_alu;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rstn = 0, rd = 0, wr = 0, dum, wq, sk;
   logic [6:0] adr = 0;
   logic [31:0] wd = 0, rdat, got;
   logic [7:0] acc, a, b, r;
   logic [7:0] m [16];
   logic [5:0] fl;
   logic [2:0] op;
   logic [3:0] ix;
   int failures = 0, n_compared = 0, seed = 32'hab92_bcc1, k;
   ssa_alu u_dut (.clk(clk), .rstn(rstn), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wq), .dummy_cycle(dum));
   initial forever #2.5 clk = ~clk;
   task conclude;
      if (failures == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(string n, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   // Request stays up until an edge samples waitrequest low
   task bus(logic w, logic [6:0] ad, logic [31:0] d);
      @(posedge clk);
      {adr, wd, wr, rd} <= {ad, d, w, !w};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wq !== 1'b0 && k < 20);
      got = rdat;
      {wr, rd} <= 2'b00;
      if (k == 20) begin
         failures++;
         conclude;
      end
   endtask
   function automatic logic [5:0] fsub(logic [7:0] x, logic [7:0] y);
      logic [7:0] d;
      logic v;
      d = x - y;
      v = (x[7] != y[7]) && (d[7] != x[7]);
      return {d == 0, !(v ^ d[7]), v, d == 0, x[3:0] >= y[3:0], x >= y};
   endfunction
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1;
      bus(1'b0, 7'h00, 32'h0);
      chk("acc", 32'h0, got);
      bus(1'b0, 7'h04, 32'h0);
      chk("status", 32'h0, got);
      bus(1'b0, 7'h0c, 32'h0);
      chk("unmapped", 32'h0, got);
      fl = 0;
      acc = 0;
      for (int i = 0; i < 16; i++) begin
         m[i] = 8'($random(seed));
         bus(1'b1, {1'b1, i[3:0], 2'b00}, {24'h0, m[i]});
      end
      for (int i = 0; i < 60; i++) begin
         op = (i % 6 == 0) ? 3'd1 : 3'({$random(seed)} % 6);
         ix = (i % 6 == 0) ? 4'd0 : 4'($random(seed));
         b = 8'($random(seed));
         // Byte 0 reloaded so both zero and nonzero skips occur
         if (i % 6 == 0) begin
            m[0] = (i % 12 == 0) ? 8'h00 : b;
            bus(1'b1, 7'h40, {24'h0, m[0]});
         end
         bus(1'b1, 7'h08, {8'h00, b, 4'h0, ix, 5'h00, op});
         a = m[ix];
         sk = op == 3'd1 && a != 0;
         r = acc - ((op == 3'd4) ? b : a);
         if (op inside {[3'd2:3'd4]})
            fl = fsub(acc, (op == 3'd4) ? b : a);
         if (op == 3'd2 || op == 3'd4)
            acc = r;
         if (op == 3'd3)
            m[ix] = r;
         if (op == 3'd5)
            m[ix] = {a[3:0], a[7:4]};
         // The dummy pulse stands from the edge after execution to the next one
         @(posedge clk);
         #1 chk("dummy", {31'h0, sk}, {31'h0, dum});
         bus(1'b0, 7'h00, 32'h0);
         chk("acc", {24'h0, acc}, got);
         bus(1'b0, 7'h04, 32'h0);
         chk("status", {23'h0, sk, 2'h0, fl}, got);
         bus(1'b0, {1'b1, ix, 2'b00}, 32'h0);
         chk("mem", {24'h0, m[ix]}, got);
      end
      conclude;
   end
endmodule
bind ssa_alu ssa_chk u_chk (.clk(clk), .rstn(rstn), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .dummy_cycle(dummy_cycle));
`default_nettype wire
